// *** wdff_consts.svh ***
// constants for the watchdog restart and fault flag block
// assumes inclusion by both design files of the block
`ifndef WDFF_CONSTS_SVH
`define WDFF_CONSTS_SVH
`define WDFF_FLAGS_ADDR    8'h09
`define WDFF_RESTART_ADDR  8'h0a
`define WDFF_EARLY_BIT     7
`define WDFF_LATE_BIT      6
`define WDFF_POR_BIT       5
`define WDFF_LOWBAK_BIT    4
`define WDFF_FLAGS_MASK    8'hf0
`define WDFF_RESTART_KEY   4'ha
`define WDFF_TICK_NS       1000
`define WDFF_CLK_NS        40
`define WDFF_TICK_CYC      (`WDFF_TICK_NS / `WDFF_CLK_NS)
`define WDFF_RST_PULSE_CYC 16
`endif

// *** wdff_pkg.sv ***
// types for the watchdog restart and fault flag block
// assumes nothing beyond a systemverilog compiler
package wdff_pkg;
  typedef enum logic [1:0] {
    WDFF_IDLE  = 2'b00,
    WDFF_RUN   = 2'b01,
    WDFF_FAULT = 2'b10
  } wdff_state_type;
endpackage : wdff_pkg

// *** wdff_tick_div.sv ***
// tick enable divider for the window timer
// assumes one free running ref_clk
`timescale 1ns/10ps
`include "wdff_consts.svh"
module wdff_tick_div #(
  parameter int DIV = `WDFF_TICK_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // enable out
  output logic      tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = (cnt_r == 16'(DIV - 1)) ? 16'h0000 : cnt_r + 16'h0001;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign tick = (cnt_r == 16'(DIV - 1));
endmodule : wdff_tick_div

// *** wdff_core.sv ***
// watchdog window checker with battery-backed fault flag register
// assumes a register port already decoded from the serial transport,
// window times in ticks, and power status levels from the supervisor
`timescale 1ns/10ps
`include "wdff_consts.svh"
// Operation
// (RULE1) restart before window opens: pull reset low, set early fault flag
// (RULE2) early fault flag stays set until software writes it clear
// (RULE3) early fault and power-on flags may both be set together
// (RULE4) early fault flag is read/write and kept by backup supply
// (RULE5) flags: early fault bit 7, power-on bit 5, low backup bit 4
// (RULE6) no restart by window close, or late restart: reset, late flag
// (RULE7) weak backup while main supply low sets low backup flag
module wdff_core #(
  parameter int TICK_DIV = `WDFF_TICK_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // watchdog window, in ticks
  input  wire logic       wd_enable,
  input  wire logic [15:0] window_open_time,
  input  wire logic [15:0] window_close_time,
  // supervisor status, from other power domains
  input  wire logic       por_event,
  input  wire logic       backup_weak,
  input  wire logic       main_below_backup,
  // reset output
  output logic            reset_out_n
);
  // one tick per microsecond of window time
  logic                     tick;
  // window timer group
  wdff_pkg::wdff_state_type st_r;
  wdff_pkg::wdff_state_type st_nxt;
  logic [15:0]              win_r;
  logic [15:0]              win_nxt;
  logic [4:0]               pulse_r;
  logic [4:0]               pulse_nxt;
  // reset output group
  logic                     rst_out_n_r;
  logic                     rst_out_n_nxt;
  // flag register group, battery-backed
  logic [7:0]               flags_r;
  logic [7:0]               flags_nxt;
  // read data group
  logic [7:0]               rdata_r;
  logic [7:0]               rdata_nxt;
  // power level synchronisers
  logic [2:0]               weak_s_r;
  logic [2:0]               weak_s_nxt;
  logic [2:0]               main_s_r;
  logic [2:0]               main_s_nxt;
  // decoded events
  logic                     flags_wr;
  logic                     restart;
  logic                     early;
  logic                     late;
  logic                     lowbak_set;

  wdff_tick_div #(.DIV(TICK_DIV)) u_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tick    (tick)
  );

  // async power levels: act once stages two and three agree
  always_comb begin
    weak_s_nxt = {weak_s_r[1:0], backup_weak};
    main_s_nxt = {main_s_r[1:0], main_below_backup};
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      weak_s_r <= 3'b000;
      main_s_r <= 3'b000;
    end else begin
      weak_s_r <= weak_s_nxt;
      main_s_r <= main_s_nxt;
    end
  end
  assign lowbak_set = (weak_s_r[2] & weak_s_r[1])
                    & (main_s_r[2] & main_s_r[1]); // RULE7

  // register writes; a restart with the wrong key is ignored
  always_comb begin
    flags_wr = 1'b0;
    restart  = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `WDFF_FLAGS_ADDR) begin
        flags_wr = 1'b1;
      end
      if (reg_addr == `WDFF_RESTART_ADDR
          && reg_wdata[3:0] == `WDFF_RESTART_KEY) begin
        restart = 1'b1;
      end
    end
  end

  // window checks only count while the timer runs
  always_comb begin
    early = 1'b0;
    late  = 1'b0;
    if (st_r == wdff_pkg::WDFF_RUN) begin
      early = restart && (win_r < window_open_time); // RULE1
      late  = (win_r >= window_close_time); // RULE6
    end
  end

  // window timer; a fault holds off the timer until the pulse ends
  always_comb begin
    st_nxt    = st_r;
    win_nxt   = win_r;
    pulse_nxt = pulse_r;
    case (st_r)
      wdff_pkg::WDFF_IDLE: begin
        win_nxt = 16'h0000;
        if (wd_enable) begin
          st_nxt = wdff_pkg::WDFF_RUN;
        end
      end
      wdff_pkg::WDFF_RUN: begin
        if (!wd_enable) begin
          st_nxt = wdff_pkg::WDFF_IDLE;
        end else if (early || late) begin
          st_nxt    = wdff_pkg::WDFF_FAULT; // RULE1 RULE6
          pulse_nxt = 5'(`WDFF_RST_PULSE_CYC);
        end else if (restart) begin
          win_nxt = 16'h0000;
        end else if (tick) begin
          win_nxt = win_r + 16'h0001;
        end
      end
      wdff_pkg::WDFF_FAULT: begin
        win_nxt = 16'h0000;
        if (pulse_r == 5'h01) begin
          st_nxt = wdff_pkg::WDFF_IDLE;
        end
        pulse_nxt = pulse_r - 5'h01;
      end
      default: begin
        st_nxt = wdff_pkg::WDFF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r    <= wdff_pkg::WDFF_IDLE;
      win_r   <= 16'h0000;
      pulse_r <= 5'h00;
    end else begin
      st_r    <= st_nxt;
      win_r   <= win_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    flags_nxt = flags_r & `WDFF_FLAGS_MASK;
    if (flags_wr) begin
      flags_nxt = reg_wdata & `WDFF_FLAGS_MASK; // RULE2 RULE4
    end
    if (early) begin
      flags_nxt[`WDFF_EARLY_BIT] = 1'b1; // RULE1
    end
    if (late) begin
      flags_nxt[`WDFF_LATE_BIT] = 1'b1; // RULE6
    end
    if (por_event) begin
      flags_nxt[`WDFF_POR_BIT] = 1'b1; // RULE3
    end
    if (lowbak_set) begin
      flags_nxt[`WDFF_LOWBAK_BIT] = 1'b1; // RULE7
    end
  end
  // battery-backed: the core reset never clears the flags, so they
  // hold unknown values until software first writes them
  always_ff @(posedge ref_clk) begin
    flags_r <= flags_nxt; // RULE4
  end

  // read data: unused and unmapped bits read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      if (reg_addr == `WDFF_FLAGS_ADDR) begin
        rdata_nxt = flags_r & `WDFF_FLAGS_MASK; // RULE5
      end else begin
        // the write-only restart register reads as zero too
        rdata_nxt = 8'h00;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // reset output from a flop: a decode of the state bits could glitch
  // low while the two state bits change together
  always_comb begin
    rst_out_n_nxt = 1'b1;
    if (st_nxt == wdff_pkg::WDFF_FAULT) begin
      rst_out_n_nxt = 1'b0; // RULE1 RULE6
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_out_n_r <= 1'b1;
    end else begin
      rst_out_n_r <= rst_out_n_nxt;
    end
  end

  assign reg_rdata   = rdata_r;
  assign reset_out_n = rst_out_n_r;
endmodule : wdff_core

// *** wdff_host.sv ***
// host model on the register port
// assumes strobes sampled on rising ref_clk
`timescale 1ns/10ps
module wdff_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // one cycle per op; idle ops pass inverted values, never stale ones
  task op(input logic w, r, input logic [7:0] a, d, output logic [7:0] q);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
    @(negedge ref_clk);
    q = reg_rdata;
  endtask : op
endmodule : wdff_host

// *** wdff_core_assertions.sv ***
// checker on wdff_core ports
// assumes bind to every wdff_core
`timescale 1ns/10ps
module wdff_chk (
  // watched ports
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       wd_enable,
  input wire logic       por_event,
  input wire logic       reset_out_n
);
  wire rd9 = reg_rd && reg_addr == 8'h09;
  wire wr9 = reg_wr && reg_addr == 8'h09;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_unused_zero: assert property (rd9 |=> !reg_rdata[3:0])
    else $error("unused bits");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h0a
    |=> !reg_rdata) else $error("unmapped");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  a_por_sets: assert property ($past(por_event) && rd9
    |=> reg_rdata[5]) else $error("por lost");
  a_pulse_len: assert property ($fell(reset_out_n) |-> !reset_out_n[*8]
    ##1 !reset_out_n[*8] ##1 reset_out_n) else $error("pulse");
  a_flag_sticky: assert property (rd9 && !wr9 ##1 rd9 && reg_rdata[7]
    |=> reg_rdata[7]) else $error("flag dropped");
  a_flag_clear: assert property (wr9 && !reg_wdata[5] && !por_event
    ##1 rd9 |=> !reg_rdata[5]) else $error("no clear");
  a_fault_enabled: assert property ($fell(reset_out_n)
    |-> $past(wd_enable)) else $error("idle fault");
  c_early: cover property (rd9 ##1 reg_rdata[7]);
  c_late: cover property (rd9 ##1 reg_rdata[6]);
  c_pulse: cover property ($fell(reset_out_n));
endmodule : wdff_chk
bind wdff_core wdff_chk u_chk (.ref_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .wd_enable, .por_event, .reset_out_n);

// *** wdff_core_tb.sv ***
// bench for wdff_core through the host model
// assumes TICK_DIV of 2 so windows close in a few cycles
`timescale 1ns/10ps
module wdff_core_tb;
  logic        ref_clk = 0, reset = 1, wd_enable = 0, por_event = 0;
  logic        backup_weak = 0, main_below_backup = 0, reset_out_n;
  logic [15:0] window_open_time = 16'h0002, window_close_time = 16'h0004;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
  logic        reg_wr, reg_rd;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 2000) begin
    n_fail++;
    final_report;
  end
  wdff_core #(.TICK_DIV(2)) dut (.ref_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .wd_enable, .window_open_time, .window_close_time,
    .por_event, .backup_weak, .main_below_backup, .reset_out_n);
  wdff_host h (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  task chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task rc(input logic [7:0] a, e);
    h.op(1'b0, 1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rc
  task wr(input logic [7:0] a, d);
    h.op(1'b1, 1'b0, a, d, q);
    h.op(1'b0, 1'b0, ~a, ~d, q);
  endtask : wr
  // bounded wait; a missing fault ends as a mismatch, not a hang
  task wait_fault;
    h.op(1'b0, 1'b0, 8'hf6, 8'hf5, q);
    for (int i = 0; i < 99 && reset_out_n; i++) @(negedge ref_clk);
    chk({7'h00, reset_out_n}, 8'h00);
  endtask : wait_fault
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    h.op(1'b0, 1'b0, 8'h00, 8'h00, q);
    repeat (5) @(negedge ref_clk);
    reset = 0;
    wr(8'h09, 8'h00);
    rc(8'h30, 8'h00);
    por_event = 1;
    wd_enable = 1;
    @(negedge ref_clk);
    por_event = 0;
    rc(8'h09, 8'h20);
    wr(8'h0a, 8'h0a);
    wait_fault;
    wd_enable = 0;
    rc(8'h09, 8'ha0);
    rc(8'h09, 8'ha0);
    rc(8'h0a, 8'h00);
    h.op(1'b1, 1'b0, 8'h09, 8'h00, q);
    rc(8'h09, 8'h00);
    $display("early fault test done");
    repeat (16) @(negedge ref_clk);
    wd_enable = 1;
    @(negedge ref_clk);
    wr(8'h0a, 8'h05);
    wait_fault;
    wd_enable = 0;
    rc(8'h09, 8'h40);
    {backup_weak, main_below_backup} = 2'b11;
    repeat (6) @(negedge ref_clk);
    rc(8'h09, 8'h50);
    $display("late and backup tests done");
    reset = 1;
    repeat (2) @(negedge ref_clk);
    reset = 0;
    chk({7'h00, reset_out_n}, 8'h01);
    rc(8'h09, 8'h50);
    $display("core reset test done");
    final_report;
  end
endmodule : wdff_core_tb
